// ==== lcg_map.svh ====
// Purpose: Register offsets, field positions and reset values of the gate input select stage
// Assumes: AXI4-Lite slave, one aligned 32-bit word per register
// Notes: Offsets are byte addresses
// Function
// R1: Gate 1 enables in select-low bits 7..0: src4 true, src4 neg, ... src1 neg.
// R2: Gate 2 enables in select-low bits 15..8, same order as gate 1.
// R3: Gate 3 enables in select-high bits 7..0, true/negated alternating per source.
// R4: Gate 4 enables in select-high bits 15..8, same order.
// R5: Negated enable set routes inverted source into gate; clear excludes it.
// R6: True enable set routes plain source into gate; clear excludes it.
// R7: Each gate ORs all its enabled true and negated sources.
// R8: Each source mux supplies both true and negated copies to the stage.
`ifndef LCG_MAP_SVH
`define LCG_MAP_SVH

`define LCG_OFF_SEL_LOW 12'h000
`define LCG_OFF_SEL_HIGH 12'h004
`define LCG_OFF_GATE_STATUS 12'h008
`define LCG_SEL_RESET 16'h0000
`define LCG_GATE_LO_LSB 0
`define LCG_GATE_HI_LSB 8
`define LCG_RESP_OKAY 2'h0
`define LCG_RESP_SLVERR 2'h2

`endif

// ==== lcg_pkg.sv ====
// Purpose: Types of the gate input select stage
// Assumes: Used with lcg_map.svh
// Notes: None
package lcg_pkg;
    typedef enum logic [0:0] {
        LCG_IDLE = 1'b0,
        LCG_RESP = 1'b1
    } lcg_bus_state_t;
endpackage

// ==== lcg_gate.sv ====
// Purpose: One input gate: enable-masked OR of true and negated sources
// Assumes: Enable byte order src4 true at bit 7 down to src1 negated at bit 0
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module lcg_gate (
    input wire logic [7:0] enable, // Enable byte for this gate
    input wire logic [3:0] src_true, // True copies, bit 0 is source 1
    input wire logic [3:0] src_neg, // Negated copies, bit 0 is source 1
    output logic gate_out // Gate result
);
    logic [7:0] terms;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            terms[2*i+1] = enable[2*i+1] & src_true[i]; // [R6]
            terms[2*i] = enable[2*i] & src_neg[i]; // [R5]
        end
    end
    assign gate_out = |terms; // [R7]
endmodule // lcg_gate
`default_nettype wire

// ==== lcg_top.sv ====
// Purpose: Gate input select stage with AXI4-Lite register access
// Assumes: Source signals are from the same clock domain
// Notes: Gate outputs are registered
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "lcg_map.svh"
module lcg_top (
    input wire logic aclk, // Clock, 20 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [3:0] source_data, // Selected data of muxes 4..1
    output logic [3:0] gate_result // Gate 4..1 results to the cell
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] sel_low_r;
    logic [15:0] sel_high_r;
    logic [3:0] gate_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    lcg_pkg::lcg_bus_state_t wst_r;
    lcg_pkg::lcg_bus_state_t rst_r;
    logic [3:0] src_true;
    logic [3:0] src_neg;
    logic [3:0] gate_comb;
    logic do_write;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) res[7:0] = data[7:0];
        if (strb[1]) res[15:8] = data[15:8];
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: capture address and data in either order
    assign s_axi_awready = !aw_held_r && (wst_r == lcg_pkg::LCG_IDLE);
    assign s_axi_wready = !w_held_r && (wst_r == lcg_pkg::LCG_IDLE);
    assign do_write = (wst_r == lcg_pkg::LCG_IDLE)
        && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    assign wa = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wd = w_held_r ? wdata_r : s_axi_wdata;
    assign ws = w_held_r ? wstrb_r : s_axi_wstrb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_low_r <= `LCG_SEL_RESET;
            sel_high_r <= `LCG_SEL_RESET;
        end else if (do_write) begin
            if ({wa[11:2], 2'b00} == `LCG_OFF_SEL_LOW)
                sel_low_r <= merge16(sel_low_r, wd, ws); // [R1] [R2]
            if ({wa[11:2], 2'b00} == `LCG_OFF_SEL_HIGH)
                sel_high_r <= merge16(sel_high_r, wd, ws); // [R3] [R4]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r <= lcg_pkg::LCG_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LCG_RESP_OKAY;
        end else begin
            case (wst_r)
                lcg_pkg::LCG_IDLE: begin
                    if (do_write) begin
                        wst_r <= lcg_pkg::LCG_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= ({wa[11:2], 2'b00} == `LCG_OFF_SEL_LOW
                            || {wa[11:2], 2'b00} == `LCG_OFF_SEL_HIGH)
                            ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
                    end
                end
                lcg_pkg::LCG_RESP: begin
                    if (s_axi_bready) begin
                        wst_r <= lcg_pkg::LCG_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: wst_r <= lcg_pkg::LCG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    assign s_axi_arready = (rst_r == lcg_pkg::LCG_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_r <= lcg_pkg::LCG_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LCG_RESP_OKAY;
        end else begin
            case (rst_r)
                lcg_pkg::LCG_IDLE: begin
                    if (s_axi_arvalid) begin
                        rst_r <= lcg_pkg::LCG_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= `LCG_RESP_OKAY;
                        case ({s_axi_araddr[11:2], 2'b00})
                            `LCG_OFF_SEL_LOW: s_axi_rdata <= {16'h0000, sel_low_r};
                            `LCG_OFF_SEL_HIGH: s_axi_rdata <= {16'h0000, sel_high_r};
                            `LCG_OFF_GATE_STATUS: s_axi_rdata <= {28'h0000000, gate_r};
                            default: begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= `LCG_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                lcg_pkg::LCG_RESP: begin
                    if (s_axi_rready) begin
                        rst_r <= lcg_pkg::LCG_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: rst_r <= lcg_pkg::LCG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate stage
    assign src_true = source_data; // [R8]
    assign src_neg = ~source_data; // [R8]

    lcg_gate u_gate1 (
        .enable(sel_low_r[`LCG_GATE_LO_LSB +: 8]), // [R1]
        .src_true(src_true),
        .src_neg(src_neg),
        .gate_out(gate_comb[0])
    );
    lcg_gate u_gate2 (
        .enable(sel_low_r[`LCG_GATE_HI_LSB +: 8]), // [R2]
        .src_true(src_true),
        .src_neg(src_neg),
        .gate_out(gate_comb[1])
    );
    lcg_gate u_gate3 (
        .enable(sel_high_r[`LCG_GATE_LO_LSB +: 8]), // [R3]
        .src_true(src_true),
        .src_neg(src_neg),
        .gate_out(gate_comb[2])
    );
    lcg_gate u_gate4 (
        .enable(sel_high_r[`LCG_GATE_HI_LSB +: 8]), // [R4]
        .src_true(src_true),
        .src_neg(src_neg),
        .gate_out(gate_comb[3])
    );

    always_ff @(posedge aclk) begin
        if (!aresetn)
            gate_r <= 4'h0;
        else
            gate_r <= gate_comb; // [R7]
    end
    assign gate_result = gate_r;
endmodule // lcg_top
`default_nettype wire

// ==== lcg_top_checker.sv ====
// Purpose: Port-level assertions for lcg_top
// Assumes: Writes present address and data together
// Notes: Shadow select registers follow bus writes
`timescale 1ns/1ns
`default_nettype none
`include "lcg_map.svh"
module lcg_top_checker (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic [11:0] s_axi_awaddr, // Addr
    input wire logic s_axi_awvalid, // Valid
    input wire logic s_axi_awready, // Ready
    input wire logic [31:0] s_axi_wdata, // Data
    input wire logic [3:0] s_axi_wstrb, // Strobes
    input wire logic s_axi_wvalid, // Valid
    input wire logic s_axi_wready, // Ready
    input wire logic [1:0] s_axi_bresp, // Resp
    input wire logic s_axi_bvalid, // Valid
    input wire logic s_axi_bready, // Ready
    input wire logic s_axi_arvalid, // Valid
    input wire logic s_axi_arready, // Ready
    input wire logic s_axi_rvalid, // Valid
    input wire logic [3:0] source_data, // Sources
    input wire logic [3:0] gate_result // Gates
);
    logic [15:0] lo_r, hi_r;
    wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic [11:0] a = s_axi_awaddr;
    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction
    function automatic logic gx(input logic [7:0] e, input logic [3:0] s);
        return |(e & {s[3], ~s[3], s[2], ~s[2], s[1], ~s[1], s[0], ~s[0]});
    endfunction
    always_ff @(posedge aclk) begin
        if (!aresetn)
            lo_r <= 16'h0;
        else if (wr_go && a == `LCG_OFF_SEL_LOW)
            lo_r <= mrg(lo_r, s_axi_wdata, s_axi_wstrb);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            hi_r <= 16'h0;
        else if (wr_go && a == `LCG_OFF_SEL_HIGH)
            hi_r <= mrg(hi_r, s_axi_wdata, s_axi_wstrb);
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take; wr_go; endsequence
    sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
    a_gate1_or: assert property (
        gate_result[0] == gx($past(lo_r[7:0]), $past(source_data)))
        else $error("Gate 1 result wrong");
    a_gate2_or: assert property (
        gate_result[1] == gx($past(lo_r[15:8]), $past(source_data)))
        else $error("Gate 2 result wrong");
    a_gate3_or: assert property (
        gate_result[2] == gx($past(hi_r[7:0]), $past(source_data)))
        else $error("Gate 3 result wrong");
    a_gate4_or: assert property (
        gate_result[3] == gx($past(hi_r[15:8]), $past(source_data)))
        else $error("Gate 4 result wrong");
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("Write response late");
    a_resp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped");
    a_bad_write: assert property (s_wr_take ##0 (a != 12'h000 && a != 12'h004)
        |=> s_axi_bresp == `LCG_RESP_SLVERR) else $error("Bad write not refused");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read response late");
endmodule // lcg_top_checker
`default_nettype wire

// ==== test_lcg_top.sv ====
// Purpose: Self-checking bench for lcg_top
// Assumes: Register map of lcg_map.svh
// Notes: Random selects, strobes and sources
`timescale 1ns/1ns
`default_nettype none
`include "lcg_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module test_lcg_top;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, x = 32'h8c2c;
    logic [3:0] s_axi_wstrb = 4'h0, source_data = 4'h0, gate_result, s;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] lo = 16'h0, hi = 16'h0;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    int errors = 0, compares = 0, cyc = 0;
    lcg_top i_lcg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_data, .gate_result);
    function automatic logic [31:0] nx(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] t);
        return {t[1] ? d[15:8] : o[15:8], t[0] ? d[7:0] : o[7:0]};
    endfunction
    function automatic logic gx(input logic [7:0] e, input logic [3:0] v);
        return |(e & {v[3], ~v[3], v[2], ~v[2], v[1], ~v[1], v[0], ~v[0]});
    endfunction
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] t,
                      input logic [1:0] e);
        wq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= t;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        // Random hold-off so the response must stand
        repeat (x[9:8]) @(posedge aclk);
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        repeat (x[21:20]) @(posedge aclk);
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, wq.pop_front())
        if (++cyc == 6000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                // Second reset in mid-run clears both selects
                aresetn <= 1'h0;
                repeat (3) @(posedge aclk);
                aresetn <= 1'h1;
                @(posedge aclk);
                lo = 16'h0;
                hi = 16'h0;
            end
            rd(`LCG_OFF_SEL_LOW, {`LCG_RESP_OKAY, 16'h0, lo});
            rd(`LCG_OFF_SEL_HIGH, {`LCG_RESP_OKAY, 16'h0, hi});
            x = nx(x);
            wr(`LCG_OFF_SEL_LOW, x, x[31:28], `LCG_RESP_OKAY);
            lo = mrg(lo, x, x[31:28]);
            x = nx(x);
            wr(`LCG_OFF_SEL_HIGH, x, x[31:28], `LCG_RESP_OKAY);
            hi = mrg(hi, x, x[31:28]);
            x = nx(x);
            s = x[3:0];
            source_data <= s;
            wr({x[11:4], 4'h8}, x, 4'hf, `LCG_RESP_SLVERR);
            rd({x[19:12], 4'hc}, {`LCG_RESP_SLVERR, 32'h0});
            rd(`LCG_OFF_GATE_STATUS, {`LCG_RESP_OKAY, 28'h0, gx(hi[15:8], s), gx(hi[7:0], s),
                gx(lo[15:8], s), gx(lo[7:0], s)});
        end
        @(posedge aclk);
        wrap_up();
    end
endmodule // test_lcg_top
bind lcg_top lcg_top_checker i_lcg_top_checker (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .source_data, .gate_result);
`default_nettype wire
